// File: hdl/pwm_pkg.sv
// types shared by the timer pair PWM block
package pwm_pkg;
  typedef enum logic [2:0] {
    MODE_INTERVAL = 3'h0,
    MODE_CAPTURE = 3'h2,
    MODE_EVENT = 3'h3,
    MODE_ONECOUNT = 3'h4,
    MODE_CAP_ONE = 3'h6
  } mode_e;
  typedef enum logic [2:0] {
    TSEL_SW = 3'h0,
    TSEL_EDGE = 3'h1,
    TSEL_BOTH = 3'h2,
    TSEL_MASTER = 3'h4
  } tsel_e;
  typedef enum logic [2:0] {
    SL_IDLE = 3'h1,
    SL_WAIT = 3'h2,
    SL_RUN = 3'h4
  } slave_st_e;
  typedef struct packed {
    logic [15:0] slave_mode;
    logic [15:0] period;
    logic [15:0] duty;
    logic [1:0] out_mode;
    logic [1:0] out_pol;
    logic [1:0] out_val;
    logic [1:0] out_en;
    logic [7:0] port_dir;
    logic [7:0] flags;
    logic [7:0] mask;
    logic [1:0] enabled;
    logic [3:0] presc_sel;
    logic [14:0] presc_cnt;
    logic [15:0] mcnt;
    logic [15:0] scnt;
    slave_st_e sst;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic dph_wr;
    logic dph_rd;
    logic [7:0] dph_addr;
    logic [31:0] rdata;
  } state_s;
endpackage : pwm_pkg

// File: hdl/pwm_regs.svh
// register offsets, field positions and reset values of the timer pair
`ifndef PWM_REGS_SVH
`define PWM_REGS_SVH
`define OFS_SLAVE_MODE 8'h00
`define OFS_PERIOD 8'h04
`define OFS_DUTY 8'h08
`define OFS_OUT_MODE 8'h0C
`define OFS_OUT_POL 8'h10
`define OFS_OUT_VAL 8'h14
`define OFS_OUT_EN 8'h18
`define OFS_PORT_DIR 8'h1C
`define OFS_IRQ_FLAG 8'h20
`define OFS_IRQ_MASK 8'h24
`define OFS_START 8'h28
`define OFS_STOP 8'h2C
`define OFS_ENABLED 8'h30
`define OFS_PRESC 8'h34
`define OFS_MCOUNT 8'h38
`define OFS_SCOUNT 8'h3C
`define CH_MASTER 0
`define CH_SLAVE 1
`define PIN_DIR_BIT 6
`define MFLAG_BIT 4
`define SFLAG_BIT 5
`define TSEL_HI 10
`define TSEL_LO 8
`define EDGE_HI 7
`define EDGE_LO 6
`define MODE_HI 3
`define MODE_LO 1
`define START_BIT 0
`define RST_MASK 8'hFF
`define RST_DIR 8'hFF
`define FLAG_IMPL 8'h30
`endif

// File: hdl/timer_pair_pwm_output.sv
// timer pair PWM generator: master sets the period, slave sets the duty
`timescale 1ns/100ps
`include "pwm_regs.svh"
module timer_pair_pwm_output
  import pwm_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic pwm_pin_i,
  output logic pwm_pin_o,
  output logic pwm_pin_oe,
  output logic master_out,
  output logic irq
);

  state_s r;
  state_s s;
  // count clock tick every 2^sel system clocks
  function automatic logic presc_tick(input logic [14:0] cnt, input logic [3:0] sel);
    logic [15:0] m;
    m = (16'h0001 << sel) - 16'h0001;
    presc_tick = ({1'b0, cnt} & m) == m;
  endfunction : presc_tick

  function automatic logic [31:0] rd_mux(input state_s q, input logic [7:0] a);
    rd_mux = 32'h0000_0000;
    case (a)
      `OFS_SLAVE_MODE: rd_mux = {16'h0000, q.slave_mode};
      `OFS_PERIOD: rd_mux = {16'h0000, q.period};
      `OFS_DUTY: rd_mux = {16'h0000, q.duty};
      `OFS_OUT_MODE: rd_mux = {30'h0, q.out_mode};
      `OFS_OUT_POL: rd_mux = {30'h0, q.out_pol};
      `OFS_OUT_VAL: rd_mux = {30'h0, q.out_val};
      `OFS_OUT_EN: rd_mux = {30'h0, q.out_en};
      `OFS_PORT_DIR: rd_mux = {24'h0, q.port_dir};
      `OFS_IRQ_FLAG: rd_mux = {24'h0, q.flags};
      `OFS_IRQ_MASK: rd_mux = {24'h0, q.mask};
      `OFS_ENABLED: rd_mux = {30'h0, q.enabled};
      `OFS_PRESC: rd_mux = {28'h0, q.presc_sel};
      `OFS_MCOUNT: rd_mux = {16'h0000, q.mcnt};
      `OFS_SCOUNT: rd_mux = {16'h0000, q.scnt};
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction : rd_mux

  always_comb
  begin
    logic tick;
    logic rise;
    logic fall;
    logic start_edge;
    logic cap_edge;
    logic ev_edge;
    logic hw_start;
    logic hw_cap;
    logic m_irq;
    logic s_irq;
    logic [1:0] sw_start;
    logic [1:0] sw_stop;
    logic [1:0] e;
    logic md0;
    mode_e mode;
    tsel_e tsel;
    logic [7:0] wa;
    logic [7:0] flag_clr;
    s = r;
    tick = presc_tick(r.presc_cnt, r.presc_sel);
    s.presc_cnt = r.presc_cnt + 15'h0001;
    rise = 1'b0;
    fall = 1'b0;
    start_edge = 1'b0;
    cap_edge = 1'b0;
    ev_edge = 1'b0;
    hw_start = 1'b0;
    hw_cap = 1'b0;
    m_irq = 1'b0;
    s_irq = 1'b0;
    sw_start = 2'b00;
    sw_stop = 2'b00;
    flag_clr = 8'h00;
    e = r.slave_mode[`EDGE_HI:`EDGE_LO];
    md0 = r.slave_mode[`START_BIT];
    mode = mode_e'(r.slave_mode[`MODE_HI:`MODE_LO]);
    tsel = tsel_e'(r.slave_mode[`TSEL_HI:`TSEL_LO]);
    wa = r.dph_addr;
    // pin input synchroniser, third stage only for edge history
    s.pin_s1 = pwm_pin_i;
    s.pin_s2 = r.pin_s1;
    s.pin_s3 = r.pin_s2;
    rise = r.pin_s2 & ~r.pin_s3;
    fall = ~r.pin_s2 & r.pin_s3;
    // valid edge decode
    unique case (e)
      2'b00: start_edge = fall;
      2'b01: start_edge = rise;
      2'b10: start_edge = fall;
      2'b11: start_edge = rise;
    endcase
    cap_edge = e[1] ? (e[0] ? fall : rise) : start_edge;
    ev_edge = e[1] ? (rise | fall) : start_edge;
    // bus address phase; reads get one wait state so hrdata comes from a flop
    s.dph_wr = hsel & htrans[1] & hready & hwrite;
    s.dph_rd = hsel & htrans[1] & hready & ~hwrite;
    if (hsel & htrans[1] & hready)
    begin
      s.dph_addr = haddr[7:0];
    end
    if (r.dph_rd)
    begin
      s.rdata = rd_mux(r, wa);
    end
    // register writes in the data phase
    if (r.dph_wr)
    begin
      case (wa)
        `OFS_SLAVE_MODE: s.slave_mode = hwdata[15:0];
        `OFS_PERIOD: s.period = hwdata[15:0];
        `OFS_DUTY: s.duty = hwdata[15:0];
        `OFS_OUT_MODE: s.out_mode = hwdata[1:0];
        `OFS_OUT_POL: s.out_pol = hwdata[1:0];
        `OFS_OUT_VAL: s.out_val = (r.out_val & r.out_en) | (hwdata[1:0] & ~r.out_en);
        `OFS_OUT_EN: s.out_en = hwdata[1:0];
        `OFS_PORT_DIR: s.port_dir = hwdata[7:0];
        `OFS_IRQ_FLAG: flag_clr = hwdata[7:0];
        `OFS_IRQ_MASK: s.mask = hwdata[7:0];
        `OFS_START: sw_start = hwdata[1:0];
        `OFS_STOP: sw_stop = hwdata[1:0];
        `OFS_PRESC: s.presc_sel = hwdata[3:0];
        default: s.slave_mode = s.slave_mode;
      endcase
    end
    // enable status: a one in start sets, a one in stop clears, a zero does nothing
    s.enabled = (r.enabled | sw_start) & ~sw_stop;
    // master channel: free-running interval timer; a stopped channel holds its count
    if (s.enabled[`CH_MASTER] & sw_start[`CH_MASTER])
    begin
      s.mcnt = r.period;
    end
    else if (s.enabled[`CH_MASTER] & tick)
    begin
      if (r.mcnt == 16'h0000)
      begin
        m_irq = 1'b1;
        s.mcnt = r.period;
      end
      else
      begin
        s.mcnt = r.mcnt - 16'h0001;
      end
    end
    // slave trigger sources
    unique case (tsel)
      TSEL_EDGE:
      begin
        hw_start = start_edge;
        hw_cap = start_edge;
      end
      TSEL_BOTH:
      begin
        hw_start = start_edge;
        hw_cap = cap_edge;
      end
      TSEL_MASTER: hw_start = m_irq;
      default: hw_start = 1'b0;
    endcase
    // slave channel
    unique case (r.sst)
      SL_IDLE:
      begin
        if (s.enabled[`CH_SLAVE])
        begin
          unique case (mode)
            MODE_ONECOUNT, MODE_CAP_ONE: s.sst = SL_WAIT;
            MODE_CAPTURE:
            begin
              s.scnt = 16'h0000;
              s_irq = md0;
              s.sst = SL_RUN;
            end
            default:
            begin
              s.scnt = r.duty;
              s_irq = md0 & (mode == MODE_INTERVAL);
              s.sst = SL_RUN;
            end
          endcase
        end
      end
      SL_WAIT:
      begin
        if (mode == MODE_CAP_ONE)
        begin
          if (hw_start)
          begin
            s.scnt = 16'h0000;
            s.sst = SL_RUN;
          end
        end
        else if (hw_start)
        begin
          if (r.duty == 16'h0000)
          begin
            s_irq = 1'b1;
          end
          else
          begin
            s.scnt = r.duty;
            s.sst = SL_RUN;
          end
        end
      end
      SL_RUN:
      begin
        unique case (mode)
          MODE_ONECOUNT:
          begin
            if (hw_start & md0)
            begin
              s.scnt = r.duty;
              s_irq = 1'b1;
            end
            else if (tick)
            begin
              if (r.scnt <= 16'h0001)
              begin
                s_irq = 1'b1;
                s.sst = SL_WAIT;
              end
              else
              begin
                s.scnt = r.scnt - 16'h0001;
              end
            end
          end
          MODE_CAP_ONE:
          begin
            if (cap_edge)
            begin
              s.duty = r.scnt;
              s_irq = 1'b1;
              s.sst = SL_WAIT;
            end
            else if (tick)
            begin
              s.scnt = r.scnt + 16'h0001;
            end
          end
          MODE_CAPTURE:
          begin
            if (hw_cap)
            begin
              s.duty = r.scnt;
              s.scnt = 16'h0000;
              s_irq = 1'b1;
            end
            else if (tick)
            begin
              s.scnt = r.scnt + 16'h0001;
            end
          end
          MODE_EVENT:
          begin
            if (ev_edge)
            begin
              if (r.scnt == 16'h0000)
              begin
                s_irq = 1'b1;
                s.scnt = r.duty;
              end
              else
              begin
                s.scnt = r.scnt - 16'h0001;
              end
            end
          end
          MODE_INTERVAL:
          begin
            if (tick)
            begin
              if (r.scnt == 16'h0000)
              begin
                s_irq = 1'b1;
                s.scnt = r.duty;
              end
              else
              begin
                s.scnt = r.scnt - 16'h0001;
              end
            end
          end
          default: s.sst = SL_WAIT; // prohibited code parks the channel
        endcase
      end
      default: s.sst = SL_IDLE;
    endcase
    if (!s.enabled[`CH_SLAVE])
    begin
      s.sst = SL_IDLE;
    end
    // timer-driven outputs; "set" means the active level
    if (r.out_en[`CH_MASTER] & m_irq)
    begin
      s.out_val[`CH_MASTER] = ~r.out_val[`CH_MASTER];
    end
    if (r.out_en[`CH_SLAVE])
    begin
      if (!r.out_mode[`CH_SLAVE] & s_irq)
      begin
        s.out_val[`CH_SLAVE] = ~r.out_val[`CH_SLAVE];
      end
      else if (r.out_mode[`CH_SLAVE] & s_irq)
      begin
        s.out_val[`CH_SLAVE] = r.out_pol[`CH_SLAVE];
      end
      else if (r.out_mode[`CH_SLAVE] & m_irq)
      begin
        s.out_val[`CH_SLAVE] = ~r.out_pol[`CH_SLAVE];
      end
    end
    // sticky request flags: a new request beats a clear in the same cycle
    s.flags = (r.flags & ~flag_clr) & `FLAG_IMPL;
    s.flags[`MFLAG_BIT] = s.flags[`MFLAG_BIT] | m_irq;
    s.flags[`SFLAG_BIT] = s.flags[`SFLAG_BIT] | s_irq;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r <= '{
        slave_mode: 16'h0000,
        period: 16'h0000,
        duty: 16'h0000,
        out_mode: 2'h0,
        out_pol: 2'h0,
        out_val: 2'h0,
        out_en: 2'h0,
        port_dir: `RST_DIR,
        flags: 8'h00,
        mask: `RST_MASK,
        enabled: 2'h0,
        presc_sel: 4'h0,
        presc_cnt: 15'h0000,
        mcnt: 16'h0000,
        scnt: 16'h0000,
        sst: SL_IDLE,
        pin_s1: 1'b0,
        pin_s2: 1'b0,
        pin_s3: 1'b0,
        dph_wr: 1'b0,
        dph_rd: 1'b0,
        dph_addr: 8'h00,
        rdata: 32'h0000_0000
      };
    end
    else
    begin
      r <= s;
    end
  end

  assign hreadyout = ~r.dph_rd;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign pwm_pin_o = r.out_val[`CH_SLAVE];
  assign pwm_pin_oe = ~r.port_dir[`PIN_DIR_BIT];
  assign master_out = r.out_val[`CH_MASTER];
  assign irq = |(r.flags & ~r.mask & `FLAG_IMPL);

endmodule : timer_pair_pwm_output

// File: test/led_load.sv
// far-side pin load: an led with a pull-up
`timescale 1ns/100ps
module led_load #(
  parameter logic PULL = 1'b1
)
(
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic pad
);
  // undriven pad floats to the pull-up, never to the last value
  assign pad = pin_oe ? pin_o : PULL;
endmodule : led_load

// File: test/pwm_chk_assertions.sv
// checker on the bus and pin ports of the timer pair block
`timescale 1ns/100ps
module pwm_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic pwm_pin_o,
  input wire logic pwm_pin_oe,
  input wire logic irq
);
  logic dw;
  logic dr;
  logic [7:0] da;
  logic dir_sh;
  logic [1:0] en_sh;
  logic [1:0] msk_sh;
  logic w14;
  assign w14 = dw && hready && da == 8'h14;
  // shadows of the registers as written over the bus
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dw <= 1'b0;
      dr <= 1'b0;
      da <= 8'h00;
      dir_sh <= 1'b1;
      en_sh <= 2'h0;
      msk_sh <= 2'h3;
    end
    else
    begin
      if (hready)
      begin
        dw <= hsel && htrans[1] && hwrite;
        dr <= hsel && htrans[1] && !hwrite;
        da <= haddr[7:0];
      end
      if (dw && hready && da == 8'h1C)
        dir_sh <= hwdata[6];
      if (dw && hready && da == 8'h18)
        en_sh <= hwdata[1:0];
      if (dw && hready && da == 8'h24)
        msk_sh <= hwdata[5:4];
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  chk_oe_follows_dir: assert property (pwm_pin_oe == !dir_sh)
    else $error("pin driver enable disagrees with direction bit");
  chk_dir_readback: assert property (dr && hreadyout && da == 8'h1C |-> hrdata[6] == dir_sh)
    else $error("direction bit reads back wrong");
  chk_irq_masked: assert property (&msk_sh |-> !irq)
    else $error("irq high while both timer flags masked");
  chk_out_frozen: assert property (!en_sh[1] && !$past(en_sh[1]) && !$past(w14) |-> $stable(pwm_pin_o))
    else $error("pin moved while timer output disabled");
  chk_out_written: assert property (!en_sh[1] && w14 |=> pwm_pin_o == $past(hwdata[1]))
    else $error("written output value not on pin");
  chk_start_reads_zero: assert property (dr && hreadyout && da == 8'h28 |-> hrdata == 32'h0)
    else $error("start register read not zero");
  chk_write_no_wait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write data phase stretched");
  chk_read_one_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait state");
  cover property ($rose(pwm_pin_o));
  cover property ($rose(irq));
  cover property (dr && hreadyout && da == 8'h28);
endmodule : pwm_chk
bind timer_pair_pwm_output pwm_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .pwm_pin_o(pwm_pin_o), .pwm_pin_oe(pwm_pin_oe), .irq(irq));

// File: test/tb.sv
// self-checking bench for the timer pair PWM block
`timescale 1ns/100ps
`include "pwm_regs.svh"
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp, pwm_pin_o, pwm_pin_oe, master_out, irq, pad;
  logic [31:0] hrdata;
  logic [31:0] rd;
  int errors = 0;
  int compares = 0;
  int h;
  int p;
  always #50 hclk = ~hclk;
  assign hready = hreadyout;
  timer_pair_pwm_output dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pwm_pin_i(pad), .pwm_pin_o(pwm_pin_o), .pwm_pin_oe(pwm_pin_oe),
    .master_out(master_out), .irq(irq));
  led_load load_u (.pin_o(pwm_pin_o), .pin_oe(pwm_pin_oe), .pad(pad));
  task give_verdict;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // sample ready at the falling edge, where it has settled
  task rdy(output logic [31:0] d);
    @(negedge hclk);
    while (hready !== 1'b1)
      @(negedge hclk);
    d = hrdata;
    @(posedge hclk);
  endtask : rdy
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy(d);
    htrans <= 2'h0;
    hwdata <= wd;
    rdy(d);
    // end off the edge so callers look at settled outputs
    @(negedge hclk);
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd, rd);
  endtask : wr
  task rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    xfer(1'b0, a, 32'h0, rd);
    chk(n, e, rd);
  endtask : rchk
  task measure(input logic act, output int hi, output int per);
    @(negedge hclk);
    while (pad === act)
      @(negedge hclk);
    while (pad !== act)
      @(negedge hclk);
    hi = 0;
    while (pad === act)
    begin
      hi++;
      @(negedge hclk);
    end
    per = hi;
    while (pad !== act)
    begin
      per++;
      @(negedge hclk);
    end
  endtask : measure
  task t_reset;
    rchk(`OFS_IRQ_MASK, 32'hFF, "mask");
    rchk(`OFS_PORT_DIR, 32'hFF, "direction");
    rchk(`OFS_IRQ_FLAG, 32'h0, "flags");
    chk("oe", 32'h0, 32'(pwm_pin_oe));
    chk("resp", 32'h0, 32'(hresp));
    chk("master out reset", 32'h0, 32'(master_out));
  endtask : t_reset
  task t_manual;
    wr(`OFS_OUT_VAL, 32'h3);
    chk("pad undriven", 32'h1, 32'(pad));
    chk("master out high", 32'h1, 32'(master_out));
    wr(`OFS_PORT_DIR, 32'hBF);
    chk("oe", 32'h1, 32'(pwm_pin_oe));
    wr(`OFS_OUT_VAL, 32'h0);
    chk("pad low", 32'h0, 32'(pad));
    chk("master out low", 32'h0, 32'(master_out));
    wr(`OFS_OUT_VAL, 32'h2);
    chk("pad high", 32'h1, 32'(pad));
    rchk(`OFS_OUT_VAL, 32'h2, "out value");
    rchk(`OFS_START, 32'h0, "start");
  endtask : t_manual
  task t_pwm;
    wr(`OFS_PERIOD, 32'h9);
    wr(`OFS_DUTY, 32'h3);
    wr(`OFS_OUT_MODE, 32'h2);
    wr(`OFS_OUT_EN, 32'h2);
    wr(`OFS_SLAVE_MODE, 32'h408);
    wr(`OFS_START, 32'h3);
    rchk(`OFS_ENABLED, 32'h3, "enabled");
    measure(1'b1, h, p);
    chk("high time", 32'h3, 32'(h));
    chk("period", 32'hA, 32'(p));
    wr(`OFS_OUT_POL, 32'h2);
    repeat (12) @(posedge hclk);
    measure(1'b0, h, p);
    chk("low time", 32'h3, 32'(h));
    chk("period inv", 32'hA, 32'(p));
  endtask : t_pwm
  task t_irq;
    xfer(1'b0, `OFS_IRQ_FLAG, 32'h0, rd);
    chk("master flag", 32'h1, 32'(rd[4]));
    chk("irq masked", 32'h0, 32'(irq));
    wr(`OFS_IRQ_MASK, 32'hEF);
    chk("irq", 32'h1, 32'(irq));
    wr(`OFS_STOP, 32'h3);
    wr(`OFS_IRQ_FLAG, 32'h30);
    rchk(`OFS_IRQ_FLAG, 32'h0, "flags cleared");
    chk("irq cleared", 32'h0, 32'(irq));
    // slave output still timer-owned, so a write must bounce
    xfer(1'b0, `OFS_OUT_VAL, 32'h0, rd);
    wr(`OFS_OUT_VAL, rd ^ 32'h2);
    rchk(`OFS_OUT_VAL, rd, "ignored write");
  endtask : t_irq
  // pad loops back to the capture input, so software-driven levels make the edges
  task t_event;
    wr(`OFS_OUT_EN, 32'h0);
    wr(`OFS_OUT_VAL, 32'h2);
    wr(`OFS_DUTY, 32'h0);
    wr(`OFS_SLAVE_MODE, 32'h46);
    wr(`OFS_IRQ_FLAG, 32'h30);
    wr(`OFS_START, 32'h2);
    wr(`OFS_OUT_VAL, 32'h0);
    repeat (4) @(posedge hclk);
    rchk(`OFS_IRQ_FLAG, 32'h0, "falling edge ignored");
    wr(`OFS_OUT_VAL, 32'h2);
    repeat (4) @(posedge hclk);
    rchk(`OFS_IRQ_FLAG, 32'h20, "rising edge counted");
    wr(`OFS_STOP, 32'h2);
    wr(`OFS_DUTY, 32'h100);
    wr(`OFS_SLAVE_MODE, 32'h1);
    wr(`OFS_IRQ_FLAG, 32'h30);
    wr(`OFS_START, 32'h2);
    rchk(`OFS_IRQ_FLAG, 32'h20, "start irq");
  endtask : t_event
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_manual;
    t_pwm;
    t_irq;
    t_event;
    give_verdict;
  end
  initial
  begin
    repeat (20000) @(posedge hclk);
    errors++;
    give_verdict;
  end
endmodule : tb
